/* design/sdrlat_pkg.sv */
`default_nettype none

package sdrlat_pkg;

    typedef enum logic [1:0] {
        SDRLAT_MEM_DDR2 = 2'h0,
        SDRLAT_MEM_DDR3 = 2'h1,
        SDRLAT_MEM_LPDDR2 = 2'h2
    } sdrlat_mem_type;

    typedef enum logic [1:0] {
        SDRLAT_RATE_FULL = 2'h0,
        SDRLAT_RATE_HALF = 2'h1,
        SDRLAT_RATE_QUARTER = 2'h2
    } sdrlat_rate_type;

    // Class index: bit1 = odd write latency, bit0 = odd read latency
    localparam logic [1:0] EVEN_WRITE_EVEN_READ_CLASS = 2'h0;
    localparam logic [1:0] EVEN_WRITE_ODD_READ_CLASS = 2'h1;
    localparam logic [1:0] ODD_WRITE_EVEN_READ_CLASS = 2'h2;
    localparam logic [1:0] ODD_WRITE_ODD_READ_CLASS = 2'h3;
    localparam int CLASS_WRITE_BIT = 1;

    localparam int LAT_W = 6;

    localparam logic [LAT_W-1:0] FULL_CTL_CMD = 6'h05;
    localparam logic [LAT_W-1:0] FULL_PHY_CMD = 6'h00;
    localparam logic [LAT_W-1:0] FULL_PHY_RET = 6'h04;
    localparam logic [LAT_W-1:0] FULL_CTL_RET = 6'h0a;

    localparam logic [LAT_W-1:0] HALF_CTL_CMD = 6'h0a;
    localparam logic [LAT_W-1:0] HALF_PHY_CMD_EVEN_WRITE = 6'h03;
    localparam logic [LAT_W-1:0] HALF_PHY_CMD_ODD_WRITE = 6'h04;
    localparam logic [LAT_W-1:0] HALF_CTL_RET = 6'h04;
    localparam logic [LAT_W-1:0] HALF_DDR2_PHY_RET = 6'h06;
    // Indexed by class: even/even, even/odd, odd/even, odd/odd
    localparam logic [4*LAT_W-1:0] HALF_DDR3_PHY_RET = {6'h07, 6'h06, 6'h06, 6'h07};

    localparam logic [LAT_W-1:0] QTR_CTL_CMD = 6'h14;
    localparam logic [LAT_W-1:0] QTR_PHY_CMD_EVEN_WRITE = 6'h08;
    localparam logic [LAT_W-1:0] QTR_PHY_CMD_ODD_WRITE = 6'h0b;
    localparam logic [LAT_W-1:0] QTR_CTL_RET = 6'h08;
    localparam logic [4*LAT_W-1:0] QTR_DDR3_PHY_RET = {6'h0e, 6'h11, 6'h11, 6'h10};

    localparam int DDR2_MEM_RD_MIN = 3;
    localparam int DDR2_MEM_RD_UPPER = 7;
    localparam int DDR3_MEM_RD_MIN = 5;
    localparam int DDR3_MEM_RD_UPPER = 11;

    localparam int HALF_RATIO = 2;
    localparam int QTR_RATIO = 4;

endpackage

`default_nettype wire

/* design/sdrlat_skid.sv */
`timescale 1ns/1ps
`default_nettype none

module sdrlat_skid #(
    parameter int WIDTH = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] slot_q [2];
    logic [1:0] count_q;
    logic rd_ptr_q;
    logic wr_ptr_q;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_q <= 2'h0;
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
        end else begin
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            slot_q[wr_ptr_q] <= in_data;
        end
    end

    // Ready only on free slot, so a receiver stall never drops a word
    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data = slot_q[rd_ptr_q];

endmodule

`default_nettype wire

/* design/sdrlat_pipe.sv */
`timescale 1ns/1ps
`default_nettype none

// Latency model of controller plus PHY, all counts in memory clock cycles.
// The module runs on the memory clock; rate shapes the local strobe and selects the stage delays.
module sdrlat_pipe
    import sdrlat_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 24,
    parameter int DEPTH = 64
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire sdrlat_mem_type mem_kind,
    input wire sdrlat_rate_type rate,
    input wire logic odd_write_latency,
    input wire logic odd_read_latency,
    // Local side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [DATA_W-1:0] rd_data,
    output logic local_tick,
    // Memory side
    output logic mem_cmd_valid,
    output logic mem_cmd_write,
    output logic [ADDR_W-1:0] mem_cmd_addr,
    output logic mem_wdata_valid,
    output logic [DATA_W-1:0] mem_wdata,
    input wire logic mem_rdata_valid,
    input wire logic [DATA_W-1:0] mem_rdata,
    // Latency report
    output logic [LAT_W-1:0] trip_no_mem,
    output logic [LAT_W-1:0] write_latency,
    output logic [15:0] last_read_latency
);

    ////////////////////////////////////////////////////////////////////////
    // Stage delays from configuration

    logic [1:0] cls;
    logic [LAT_W-1:0] ctl_cmd;
    logic [LAT_W-1:0] phy_cmd;
    logic [LAT_W-1:0] phy_ret;
    logic [LAT_W-1:0] ctl_ret;
    logic [1:0] ratio_m1;

    assign cls = {odd_write_latency, odd_read_latency};

    always_comb begin
        ctl_cmd = FULL_CTL_CMD;
        phy_cmd = FULL_PHY_CMD;
        phy_ret = FULL_PHY_RET;
        ctl_ret = FULL_CTL_RET;
        ratio_m1 = 2'h0;
        unique case (rate)
            SDRLAT_RATE_HALF: begin
                ratio_m1 = 2'(HALF_RATIO - 1);
                ctl_cmd = HALF_CTL_CMD;
                phy_cmd = cls[CLASS_WRITE_BIT] ? HALF_PHY_CMD_ODD_WRITE : HALF_PHY_CMD_EVEN_WRITE;
                ctl_ret = HALF_CTL_RET;
                if (mem_kind == SDRLAT_MEM_DDR2) begin
                    phy_ret = HALF_DDR2_PHY_RET;
                end else begin
                    phy_ret = HALF_DDR3_PHY_RET[cls*LAT_W +: LAT_W];
                end
            end
            SDRLAT_RATE_QUARTER: begin
                ratio_m1 = 2'(QTR_RATIO - 1);
                ctl_cmd = QTR_CTL_CMD;
                phy_cmd = cls[CLASS_WRITE_BIT] ? QTR_PHY_CMD_ODD_WRITE : QTR_PHY_CMD_EVEN_WRITE;
                ctl_ret = QTR_CTL_RET;
                phy_ret = QTR_DDR3_PHY_RET[cls*LAT_W +: LAT_W];
            end
            default: begin
                // Full rate for all three memories
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Local-side strobe: one memory cycle in every 1, 2 or 4

    logic [1:0] phase_q;
    logic tick;

    assign tick = (phase_q == ratio_m1);

    always_ff @(posedge clk_sys) begin
        if (rst || tick) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            local_tick <= 1'b0;
        end else begin
            local_tick <= tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command path: delay line indexed by free-running time stamp

    localparam int TW = 16;
    logic [TW-1:0] now_q;
    logic accept;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            now_q <= '0;
        end else begin
            now_q <= now_q + 16'h0001;
        end
    end

    // One request in flight at a time, read or write, keeps the model exact
    logic busy_q;
    logic [TW-1:0] issue_at_q;
    logic [TW-1:0] accept_t_q;
    logic cmd_write_q;
    logic [ADDR_W-1:0] cmd_addr_q;
    logic [DATA_W-1:0] cmd_data_q;
    logic wait_rd_q;

    assign accept = req_valid && req_ready;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= tick && !busy_q && !accept && !wait_rd_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_q <= 1'b0;
            issue_at_q <= '0;
            accept_t_q <= '0;
            cmd_write_q <= 1'b0;
            cmd_addr_q <= '0;
            cmd_data_q <= '0;
        end else if (accept) begin
            busy_q <= 1'b1;
            accept_t_q <= now_q;
            // Combined controller and PHY command delay
            issue_at_q <= now_q + TW'(ctl_cmd) + TW'(phy_cmd) - 16'h0001;
            cmd_write_q <= req_write;
            cmd_addr_q <= req_addr;
            cmd_data_q <= req_wdata;
        end else if (busy_q && now_q == issue_at_q) begin
            busy_q <= 1'b0;
        end
    end

    logic issue;
    assign issue = busy_q && (now_q == issue_at_q);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mem_cmd_valid <= 1'b0;
            mem_cmd_write <= 1'b0;
            mem_cmd_addr <= '0;
            mem_wdata_valid <= 1'b0;
            mem_wdata <= '0;
        end else begin
            mem_cmd_valid <= issue;
            mem_cmd_write <= issue && cmd_write_q;
            mem_wdata_valid <= issue && cmd_write_q;
            if (issue) begin
                mem_cmd_addr <= cmd_addr_q;
                mem_wdata <= cmd_data_q;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            write_latency <= '0;
            trip_no_mem <= '0;
        end else begin
            write_latency <= ctl_cmd + phy_cmd;
            trip_no_mem <= ctl_cmd + phy_cmd + phy_ret + ctl_ret;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read return path: memory data delayed by PHY and controller return

    localparam int PW = $clog2(DEPTH);
    logic [DATA_W-1:0] ret_mem [DEPTH];
    logic [TW-1:0] ret_due [DEPTH];
    logic [PW:0] ret_wr_q;
    logic [PW:0] ret_rd_q;
    logic ret_head;
    logic [DATA_W-1:0] ret_head_data;
    logic skid_ready;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wait_rd_q <= 1'b0;
        end else if (accept && !req_write) begin
            wait_rd_q <= 1'b1;
        end else if (rd_valid && rd_ready) begin
            wait_rd_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (mem_rdata_valid) begin
            ret_mem[ret_wr_q[PW-1:0]] <= mem_rdata;
            ret_due[ret_wr_q[PW-1:0]] <= now_q + TW'(phy_ret) + TW'(ctl_ret) - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ret_wr_q <= '0;
            ret_rd_q <= '0;
        end else begin
            if (mem_rdata_valid) begin
                ret_wr_q <= ret_wr_q + 1'b1;
            end
            if (ret_head && skid_ready) begin
                ret_rd_q <= ret_rd_q + 1'b1;
            end
        end
    end

    // A late slot waits on stall; due test uses signed distance
    logic [TW-1:0] slack;
    assign slack = now_q - ret_due[ret_rd_q[PW-1:0]];
    assign ret_head = (ret_wr_q != ret_rd_q) && !slack[TW-1];
    assign ret_head_data = ret_mem[ret_rd_q[PW-1:0]];

    logic skid_valid;
    logic [DATA_W-1:0] skid_data;

    sdrlat_skid #(
        .WIDTH(DATA_W)
    ) u_skid (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(ret_head),
        .in_ready(skid_ready),
        .in_data(ret_head_data),
        .out_valid(skid_valid),
        .out_ready(rd_ready || !rd_valid),
        .out_data(skid_data)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data <= '0;
        end else if (rd_ready || !rd_valid) begin
            rd_valid <= skid_valid;
            rd_data <= skid_data;
        end
    end

    // Measured latency; users must allow for reset-to-reset drift
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            last_read_latency <= '0;
        end else if (skid_valid && (rd_ready || !rd_valid)) begin
            last_read_latency <= now_q + 16'h0001 - accept_t_q;
        end
    end

endmodule

`default_nettype wire

/* tb/sdrlat_pipe_props.sv */
`timescale 1ns/1ps
`default_nettype none

module sdrlat_pipe_props
    import sdrlat_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire sdrlat_mem_type mem_kind,
    input wire sdrlat_rate_type rate,
    input wire logic odd_write_latency,
    input wire logic odd_read_latency,
    input wire logic req_ready,
    input wire logic rd_valid,
    input wire logic rd_ready,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic local_tick,
    input wire logic mem_cmd_valid,
    input wire logic [LAT_W-1:0] trip_no_mem,
    input wire logic [LAT_W-1:0] write_latency
);
    logic [5:0] cfg_q;
    logic [1:0] stab_q;
    wire logic [5:0] cfg = {mem_kind, rate, odd_write_latency, odd_read_latency};
    wire logic [1:0] cls = {odd_write_latency, odd_read_latency};
    // Latency and tick outputs only judged once the selection has settled
    wire logic ok = stab_q == 2'h3 && cfg == cfg_q;
    always_ff @(posedge clk_sys) begin
        cfg_q <= cfg;
        stab_q <= (rst || cfg != cfg_q) ? 2'h0 : stab_q + {1'b0, stab_q != 2'h3};
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    full_trip_a: assert property (ok && rate == SDRLAT_RATE_FULL
        |-> trip_no_mem == 6'h13 && write_latency == 6'h05) else $error("full rate figures");
    half_wl_a: assert property (ok && rate == SDRLAT_RATE_HALF
        |-> write_latency == (odd_write_latency ? 6'h0e : 6'h0d)) else $error("half write latency");
    half_ddr2_a: assert property (ok && rate == SDRLAT_RATE_HALF && mem_kind == SDRLAT_MEM_DDR2
        |-> trip_no_mem == (odd_write_latency ? 6'h18 : 6'h17)) else $error("half ddr2 trip");
    half_cls_a: assert property (ok && rate == SDRLAT_RATE_HALF && mem_kind != SDRLAT_MEM_DDR2
        |-> trip_no_mem == (cls == 2'h3 ? 6'h19 : cls == 2'h1 ? 6'h17 : 6'h18)) else $error("half trip");
    qtr_trip_a: assert property (ok && rate == SDRLAT_RATE_QUARTER
        |-> trip_no_mem == (cls == 2'h2 ? 6'h38 : cls == 2'h0 ? 6'h34 : 6'h35)) else $error("qtr trip");
    qtr_wl_a: assert property (ok && rate == SDRLAT_RATE_QUARTER
        |-> write_latency == (odd_write_latency ? 6'h1f : 6'h1c)) else $error("qtr write latency");
    tick_full_a: assert property (ok && rate == SDRLAT_RATE_FULL |-> local_tick)
        else $error("full tick");
    tick_half_a: assert property (ok && rate == SDRLAT_RATE_HALF && local_tick
        |=> (!local_tick || !ok) ##1 (local_tick || !ok)) else $error("half tick");
    rd_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
        else $error("read data dropped");
    cmd_pulse_a: assert property (mem_cmd_valid |=> !mem_cmd_valid)
        else $error("command pulse");
    busy_ref_a: assert property (rd_valid |-> !req_ready)
        else $error("accept while busy");
endmodule

bind sdrlat_pipe sdrlat_pipe_props #(.DATA_W(DATA_W)) u_props (.clk_sys(clk_sys), .rst(rst),
    .mem_kind(mem_kind), .rate(rate), .odd_write_latency(odd_write_latency),
    .odd_read_latency(odd_read_latency), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_data(rd_data), .local_tick(local_tick), .mem_cmd_valid(mem_cmd_valid),
    .trip_no_mem(trip_no_mem), .write_latency(write_latency));

`default_nettype wire

/* tb/sdrlat_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

module sdrlat_mem_model (
    input wire logic clk_sys,
    input wire logic mem_cmd_valid,
    input wire logic mem_cmd_write,
    input wire logic [23:0] mem_cmd_addr,
    input wire logic [3:0] dly,
    output logic mem_rdata_valid,
    output logic [31:0] mem_rdata
);
    logic [3:0] cnt_q = 4'h0;
    logic [23:0] addr_q = 24'h0;
    wire logic fire = cnt_q != 4'h0 && cnt_q == dly - 4'h1;
    initial mem_rdata_valid = 1'b0;
    initial mem_rdata = 32'h0;
    // Word appears dly cycles after the command
    always @(posedge clk_sys) begin
        if (mem_cmd_valid && !mem_cmd_write) begin
            cnt_q <= 4'h1;
            addr_q <= mem_cmd_addr;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= fire ? 4'h0 : cnt_q + 4'h1;
        end
    end
    // Idle bus toggles so stale data looks right only on every other cycle
    always @(posedge clk_sys) begin
        mem_rdata_valid <= fire;
        mem_rdata <= fire ? {8'h5a, addr_q} : ~mem_rdata;
    end
endmodule

`default_nettype wire

/* tb/sdrlat_pipe_test.sv */
`timescale 1ns/1ps
`default_nettype none

module sdrlat_pipe_test
    import sdrlat_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    sdrlat_mem_type mem_kind = SDRLAT_MEM_DDR2;
    sdrlat_rate_type rate = SDRLAT_RATE_FULL;
    logic odd_w = 1'b0;
    logic odd_r = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [23:0] req_addr = 24'h0;
    logic [31:0] req_wdata = 32'h0;
    logic rd_ready = 1'b1;
    logic [3:0] dly = 4'h3;
    logic req_ready, rd_valid, tick, cmd_v, cmd_w, wd_v, mr_v;
    logic [31:0] rd_data, wdata, mr_d, got;
    logic [23:0] cmd_a;
    logic [5:0] trip, wl;
    logic [15:0] lrl;
    int checked = 0;
    int n_mismatch = 0;
    int cyc = 0;

    sdrlat_pipe u_dut (.clk_sys(clk_sys), .rst(rst), .mem_kind(mem_kind), .rate(rate),
        .odd_write_latency(odd_w), .odd_read_latency(odd_r), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .local_tick(tick),
        .mem_cmd_valid(cmd_v), .mem_cmd_write(cmd_w), .mem_cmd_addr(cmd_a), .mem_wdata_valid(wd_v),
        .mem_wdata(wdata), .mem_rdata_valid(mr_v), .mem_rdata(mr_d), .trip_no_mem(trip),
        .write_latency(wl), .last_read_latency(lrl));
    sdrlat_mem_model u_mem (.clk_sys(clk_sys), .mem_cmd_valid(cmd_v), .mem_cmd_write(cmd_w),
        .mem_cmd_addr(cmd_a), .dly(dly), .mem_rdata_valid(mr_v), .mem_rdata(mr_d));

    initial forever #2.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %0h got %0h", nm, e, g);
        end
    endtask
    // Skew of one cycle tolerated, as after a board reset
    task automatic chk_rng(input string nm, input int lo, input logic [31:0] g);
        checked++;
        if ($isunknown(g) || g < lo || g > lo + 1) begin
            n_mismatch++;
            $display("wrong value %s exp %0d..%0d got %0d", nm, lo, lo + 1, g);
        end
    endtask
    function automatic int e_wl(int r, int c);
        return r == 0 ? 5 : r == 1 ? 13 + c[1] : 28 + 3 * c[1];
    endfunction
    function automatic int e_trip(int m, int r, int c);
        int q[4] = '{52, 53, 56, 53};
        int h[4] = '{24, 23, 24, 25};
        if (r == 0) return 19;
        if (r == 2) return q[c];
        return m == 0 ? 23 + c[1] : h[c];
    endfunction
    task automatic set_cfg(input int m, input int r, input int c, input int d);
        @(posedge clk_sys);
        mem_kind <= sdrlat_mem_type'(m);
        rate <= sdrlat_rate_type'(r);
        {odd_w, odd_r} <= 2'(c);
        dly <= 4'(d);
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic xfer(input logic wr, input logic [23:0] a, input logic [31:0] d, output int n);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        do @(posedge clk_sys); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        n = 0;
        // Looked at in the edge's own step, so n ends on the edge that samples it
        do begin @(posedge clk_sys); n++; end while (cmd_v !== 1'b1 && n < 300);
        chk("cmd", {wr, wr, a}, {cmd_w, wd_v, cmd_a});
        if (!wr) begin
            do begin @(posedge clk_sys); n++; end while (rd_valid !== 1'b1 && n < 300);
            got = rd_data;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_tick();
        logic [31:0] cnt;
        for (int r = 0; r < 3; r++) begin
            set_cfg(0, r, 0, 3);
            cnt = 32'h0;
            repeat (16) begin @(posedge clk_sys); #1; cnt = cnt + tick; end
            chk("ticks", 32'(16 >> r), cnt);
        end
    endtask
    task automatic t_sweep();
        int n, d;
        for (int m = 0; m < 3; m++) for (int r = 0; r < 3; r++) for (int c = 0; c < 4; c++) begin
            d = m == 0 ? (c[0] ? DDR2_MEM_RD_UPPER : DDR2_MEM_RD_MIN) : (c[0] ? DDR3_MEM_RD_UPPER : DDR3_MEM_RD_MIN);
            set_cfg(m, r, c, d);
            chk("trip", e_trip(m, r, c), trip);
            chk("wl", e_wl(r, c), wl);
            xfer(1'b1, 24'h100 + 24'(c), 32'hc0de0000 + m, n);
            chk("wr lat", e_wl(r, c), n);
            chk("wdata", 32'hc0de0000 + m, wdata);
            xfer(1'b0, 24'h200 + 24'(r), 32'h0, n);
            chk_rng("rd lat", e_trip(m, r, c) + d, n);
            chk("rdata", {8'h5a, 24'h200 + 24'(r)}, got);
            repeat (2) @(posedge clk_sys);
            chk_rng("last lat", e_trip(m, r, c) + d, lrl);
        end
    endtask
    task automatic t_stall();
        int n;
        set_cfg(1, 1, 3, 8);
        rd_ready <= 1'b0;
        xfer(1'b0, 24'h3a5, 32'h0, n);
        repeat (4) begin @(posedge clk_sys); #1; end
        chk("held", {1'b1, 1'b0}, {rd_valid, req_ready});
        chk("held data", 32'h5a0003a5, rd_data);
        @(posedge clk_sys);
        rd_ready <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("taken", 1'b0, rd_valid);
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_tick();
        t_sweep();
        t_stall();
        stop_test();
    end
endmodule

`default_nettype wire
